/* core/rrnf_defs.svh */
// register offsets, reset values and field positions of the node filter
// assumes byte addresses on a 32-bit apb bus, one register per aligned word
`ifndef RRNF_DEFS_SVH
`define RRNF_DEFS_SVH

`define RRNF_OFF_ASYNC_LO_SET 12'h108
`define RRNF_OFF_ASYNC_LO_CLR 12'h10C
`define RRNF_OFF_PHYS_HI_SET 12'h110
`define RRNF_OFF_PHYS_HI_CLR 12'h114
`define RRNF_MASK_RST 32'h0000_0000
`define RRNF_REMOTE_BIT 31
`define RRNF_NODE_BCAST 6'h3F
`define RRNF_NODE_MSB 5
`define RRNF_NODE_W 6
`define RRNF_BUS_W 10

`endif

/* core/rrnf_pkg.sv */
// types shared by the receive node filter files
// assumes rrnf_defs.svh supplies the field widths
`include "rrnf_defs.svh"

package rrnf_pkg;
    typedef logic [`RRNF_NODE_W-1:0] rrnf_node_t;
    typedef logic [`RRNF_BUS_W-1:0] rrnf_bus_t;
    typedef logic [31:0] rrnf_word_t;
endpackage

/* core/rrnf_mask_reg.sv */
// one read/set/clear mask register
// assumes set and clear strobes are one-cycle pulses from the bus slave
`timescale 1ns/1ps
`default_nettype none
`include "rrnf_defs.svh"

module rrnf_mask_reg #(
    parameter int WIDTH = 32
) (
    input wire logic pclk, // register clock
    input wire logic presetn, // async reset, active low
    input wire logic set_we, // write-ones-to-set strobe
    input wire logic clr_we, // write-ones-to-clear strobe
    input wire logic [WIDTH-1:0] wdata, // write data
    output logic [WIDTH-1:0] value // current mask
);
    logic [WIDTH-1:0] mask_r;
    logic [WIDTH-1:0] mask_nxt;

    assign mask_nxt = set_we ? (mask_r | wdata) : clr_we ? (mask_r & ~wdata) : mask_r;
    assign value = mask_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_r <= WIDTH'(`RRNF_MASK_RST);
        else
            mask_r <= mask_nxt;
    end
endmodule
`default_nettype wire

/* core/rrnf_filter.sv */
// receive request node filter: apb register bank and per-request decision
// assumes the upper async mask and lower physical mask come from elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "rrnf_defs.svh"

// Behaviour
// - local node 0..31 accepted only when its lower async mask bit is one
// - lower async mask readable, set and clear by writing ones, resets to zero
// - upper physical mask readable, set and clear by writing ones, resets zero
// - physical-bound packet checked against async masks, then physical mask
// - physical mask bit zero sends request to async request receive context
// - upper physical bits 30..18 map nodes 62..50 to physical context
// - upper physical bit 31 lets remote-bus requests use physical context
// - async mask bit zero means no acknowledge and no queueing
// - remote-bus sources accepted only when upper async bit 31 is set
// - upper physical bits 17..0 map nodes 49..32 to physical context
module rrnf_filter (
    input wire logic pclk, // register clock, 50 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high is write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [31:0] async_filter_high_in, // upper async mask, kept elsewhere
    input wire logic [31:0] phys_filter_low_in, // lower physical mask, kept elsewhere
    input wire logic [`RRNF_BUS_W-1:0] local_bus_id, // our own bus number
    input wire logic req_valid, // received request present, one cycle
    input wire logic [15:0] req_src_id, // source id: bus number, node number
    input wire logic req_phys, // request aimed at physical context
    output logic dec_valid, // decision valid, one cycle
    output logic dec_accept, // acknowledge and queue
    output logic dec_phys, // deliver to physical request context
    output logic dec_async_request_receive_context // deliver to async request receive context
);
    function automatic logic node_bit(input logic [31:0] lo, input logic [31:0] hi,
                                      input rrnf_pkg::rrnf_node_t node);
        // nodes 0..31 in lo, 32..62 in hi; broadcast node has no bit
        if (node == `RRNF_NODE_BCAST)
            node_bit = 1'b0;
        else if (node[`RRNF_NODE_MSB])
            node_bit = hi[node[`RRNF_NODE_MSB-1:0]];
        else
            node_bit = lo[node[`RRNF_NODE_MSB-1:0]];
    endfunction

    rrnf_pkg::rrnf_word_t async_lo;
    rrnf_pkg::rrnf_word_t phys_hi;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic dec_valid_r;
    logic dec_accept_r;
    logic dec_phys_r;
    logic dec_async_request_receive_context_r;

    // apb decode
    wire sel_alo_set = (paddr == `RRNF_OFF_ASYNC_LO_SET);
    wire sel_alo_clr = (paddr == `RRNF_OFF_ASYNC_LO_CLR);
    wire sel_phi_set = (paddr == `RRNF_OFF_PHYS_HI_SET);
    wire sel_phi_clr = (paddr == `RRNF_OFF_PHYS_HI_CLR);
    wire sel_alo = sel_alo_set | sel_alo_clr;
    wire sel_phi = sel_phi_set | sel_phi_clr;
    wire mapped = sel_alo | sel_phi;
    wire setup = psel & ~penable;
    wire wr_go = psel & penable & pready_r & pwrite & mapped;
    wire [31:0] rd_mux = sel_alo ? async_lo : sel_phi ? phys_hi : `RRNF_MASK_RST;

    rrnf_mask_reg #(.WIDTH(32)) u_async_lo (
        .pclk(pclk),
        .presetn(presetn),
        .set_we(wr_go & sel_alo_set),
        .clr_we(wr_go & sel_alo_clr),
        .wdata(pwdata),
        .value(async_lo)
    );

    rrnf_mask_reg #(.WIDTH(32)) u_phys_hi (
        .pclk(pclk),
        .presetn(presetn),
        .set_we(wr_go & sel_phi_set),
        .clr_we(wr_go & sel_phi_clr),
        .wdata(pwdata),
        .value(phys_hi)
    );

    // request decision
    wire [`RRNF_BUS_W-1:0] src_bus = req_src_id[15:`RRNF_NODE_W];
    wire rrnf_pkg::rrnf_node_t src_node = req_src_id[`RRNF_NODE_W-1:0];
    wire src_local = (src_bus == local_bus_id);
    wire async_hit = node_bit(async_lo, async_filter_high_in, src_node);
    wire phys_hit = node_bit(phys_filter_low_in, phys_hi, src_node);
    wire async_ok = src_local ? async_hit : async_filter_high_in[`RRNF_REMOTE_BIT];
    wire phys_ok = src_local ? phys_hit : phys_hi[`RRNF_REMOTE_BIT];
    wire route_phys = req_phys & async_ok & phys_ok;
    wire route_async_request_receive_context = async_ok & ~route_phys;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup & ~pwrite)
                prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dec_valid_r <= 1'b0;
            dec_accept_r <= 1'b0;
            dec_phys_r <= 1'b0;
            dec_async_request_receive_context_r <= 1'b0;
        end
        else
        begin
            dec_valid_r <= req_valid;
            dec_accept_r <= req_valid & async_ok;
            dec_phys_r <= req_valid & route_phys;
            dec_async_request_receive_context_r <= req_valid & route_async_request_receive_context;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dec_valid = dec_valid_r;
    assign dec_accept = dec_accept_r;
    assign dec_phys = dec_phys_r;
    assign dec_async_request_receive_context = dec_async_request_receive_context_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire lo_node = src_local & ~src_node[`RRNF_NODE_MSB];
    wire hi_node = src_local & src_node[`RRNF_NODE_MSB] & (src_node != `RRNF_NODE_BCAST);
    wire [`RRNF_NODE_MSB-1:0] node_idx = src_node[`RRNF_NODE_MSB-1:0];

    a_low_node_drop: assert property (
        req_valid & lo_node & ~async_lo[src_node[4:0]] |=> dec_valid & ~dec_accept & ~dec_async_request_receive_context)
        else $error("lower node with clear async bit was accepted");
    a_low_node_take: assert property (
        req_valid & lo_node & async_lo[src_node[4:0]] |=> dec_accept & (dec_phys ^ dec_async_request_receive_context))
        else $error("lower node with set async bit not delivered");
    a_async_set_wr: assert property (
        psel & penable & pready & pwrite & (paddr == `RRNF_OFF_ASYNC_LO_SET)
        |=> (async_lo & $past(pwdata)) == $past(pwdata))
        else $error("async set write did not set bits");
    a_async_clr_wr: assert property (
        psel & penable & pready & pwrite & (paddr == `RRNF_OFF_ASYNC_LO_CLR)
        |=> (async_lo & $past(pwdata)) == 32'h0000_0000)
        else $error("async clear write did not clear bits");
    a_phys_readback: assert property (
        setup & ~pwrite & sel_phi & ~wr_go ##1 psel & penable |-> prdata == phys_hi)
        else $error("physical mask read returned wrong value");
    a_phys_fallback: assert property (
        req_valid & req_phys & async_ok & hi_node & ~phys_hi[src_node[4:0]]
        |=> dec_async_request_receive_context & ~dec_phys)
        else $error("physical request with clear bit not sent to async_request_receive_context");
    a_phys_route: assert property (
        req_valid & req_phys & async_ok & hi_node & phys_hi[src_node[4:0]] |=> dec_phys)
        else $error("physical request with set bit not routed to physical");
    a_remote_gate: assert property (
        req_valid & ~src_local |=> dec_accept == $past(async_filter_high_in[31])
        && dec_phys == ($past(async_filter_high_in[31] & phys_hi[31] & req_phys)))
        else $error("remote bus request filtered wrongly");
    a_apb_ready: assert property (setup |=> pready ##1 ~pready || setup)
        else $error("apb answer not one access cycle");
    a_phys_set_wr: assert property (
        psel & penable & pready & pwrite & (paddr == `RRNF_OFF_PHYS_HI_SET)
        |=> (phys_hi & $past(pwdata)) == $past(pwdata))
        else $error("physical set write did not set bits");
    a_phys_clr_wr: assert property (
        psel & penable & pready & pwrite & (paddr == `RRNF_OFF_PHYS_HI_CLR)
        |=> (phys_hi & $past(pwdata)) == 32'h0000_0000)
        else $error("physical clear write did not clear bits");
    a_async_readback: assert property (
        setup & ~pwrite & sel_alo ##1 psel & penable |-> prdata == async_lo)
        else $error("async mask read returned wrong value");
    a_unmapped_err: assert property (
        setup & ~mapped |=> pready & pslverr)
        else $error("unmapped address answered without error");
    a_mapped_no_err: assert property (
        setup & mapped |=> pready & ~pslverr)
        else $error("mapped address answered with error");
    a_dec_idle: assert property (
        ~req_valid |=> ~dec_valid & ~dec_accept & ~dec_phys & ~dec_async_request_receive_context)
        else $error("decision outputs active without a request");
    a_bcast_drop: assert property (
        req_valid & src_local & (src_node == `RRNF_NODE_BCAST) |=> dec_valid & ~dec_accept)
        else $error("broadcast source node was accepted");
    a_phys_needs_req: assert property (
        req_valid & ~req_phys |=> ~dec_phys)
        else $error("non-physical request routed to physical context");
    a_low_phys_route: assert property (
        req_valid & req_phys & lo_node & async_lo[node_idx]
        |=> dec_phys == $past(phys_filter_low_in[node_idx]))
        else $error("lower node physical routing wrong");
    a_high_node_drop: assert property (
        req_valid & hi_node & ~async_filter_high_in[node_idx] |=> ~dec_accept)
        else $error("upper node with clear async bit was accepted");

    c_phys_hit: cover property (dec_phys);
    c_async_request_receive_context_fallback: cover property (dec_async_request_receive_context & $past(req_phys));
    c_dropped: cover property (dec_valid & ~dec_accept);
    c_bad_addr: cover property (pready & pslverr);
    c_remote_accept: cover property (dec_accept & $past(~src_local));
endmodule
`default_nettype wire

/* bench/rrnf_node_src.sv */
// partner: a serial-bus node that presents received requests to the filter
// assumes a one-cycle request pulse that is taken at a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module rrnf_node_src (
    input wire logic pclk, // register clock
    output logic req_valid, // request pulse
    output logic [15:0] req_src_id, // bus and node number
    output logic req_phys // aimed at physical context
);
    initial
    begin
        req_valid = 1'b0;
        req_src_id = 16'h0000;
        req_phys = 1'b0;
    end
    task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic phys);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_src_id <= {bus, node};
        req_phys <= phys;
        @(posedge pclk);
        // no stale source left on the lines
        req_valid <= 1'b0;
        req_src_id <= ~{bus, node};
        req_phys <= ~phys;
    endtask
endmodule
`default_nettype wire

/* bench/receive_request_node_filter_bench.sv */
// bench: apb register checks and request decisions of the node filter
// assumes rrnf_filter answers apb with no wait state and decides in one cycle
`timescale 1ns/1ps
`default_nettype none
module receive_request_node_filter_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, ah = 32'h0, rd, pl = 32'h8000_0000;
    logic pready, pslverr, req_valid, req_phys, dv, da, dp, dq, er;
    logic [15:0] req_src_id;
    int bad_count = 0, checks = 0;
    logic [20:0] tv [8] = '{
        {1'b1, 10'h005, 6'h1F, 1'b1, 3'b110}, {1'b1, 10'h005, 6'h00, 1'b1, 3'b000},
        {1'b1, 10'h005, 6'h32, 1'b1, 3'b110}, {1'b1, 10'h005, 6'h20, 1'b1, 3'b101},
        {1'b1, 10'h006, 6'h03, 1'b1, 3'b110}, {1'b0, 10'h006, 6'h03, 1'b1, 3'b000},
        {1'b1, 10'h005, 6'h1F, 1'b0, 3'b101}, {1'b1, 10'h005, 6'h3F, 1'b0, 3'b000}};
    always #10 pclk = ~pclk;
    rrnf_node_src src_u (.pclk(pclk), .req_valid(req_valid), .req_src_id(req_src_id),
        .req_phys(req_phys));
    rrnf_filter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .async_filter_high_in(ah), .phys_filter_low_in(pl),
        .local_bus_id(10'h005), .req_valid(req_valid), .req_src_id(req_src_id),
        .req_phys(req_phys), .dec_valid(dv), .dec_accept(da), .dec_phys(dp), .dec_async_request_receive_context(dq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #40000;
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h108, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h114, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h108, 32'h8000_0001);
        apb(1'b1, 12'h10C, 32'h0000_0001);
        apb(1'b0, 12'h10C, 32'h0);
        chk(rd, 32'h8000_0000);
        apb(1'b1, 12'h110, 32'h8004_0001);
        apb(1'b1, 12'h114, 32'h0000_0001);
        apb(1'b0, 12'h110, 32'h0);
        chk(rd, 32'h8004_0000);
        apb(1'b1, 12'h200, 32'hFFFF_FFFF);
        apb(1'b0, 12'h200, 32'h0);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b0, 12'h108, 32'h0);
        chk(rd, 32'h8000_0000);
        foreach (tv[i])
        begin
            @(posedge pclk);
            ah <= {tv[i][20], 31'h0004_0001};
            src_u.send(tv[i][19:10], tv[i][9:4], tv[i][3]);
            #1;
            chk({dv, da, dp, dq}, {1'b1, tv[i][2:0]});
            @(posedge pclk);
            #1;
            chk({dv, da, dp, dq}, 4'h0);
        end
        @(posedge pclk);
        pl <= 32'h0000_0000;
        src_u.send(10'h005, 6'h1F, 1'b1);
        #1;
        chk({dv, da, dp, dq}, 4'hD);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h108, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h110, 32'h0);
        chk(rd, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
